// ### shared/cit_pkg.sv
// shared constants and carrier types for the cascaded interval timer
package cit_pkg;

    // ========================================================================
    // register offsets (byte addresses, one aligned word each)
    // ========================================================================
    localparam int           ADDR_WIDTH     = 8;
    localparam logic [7:0]   OFS_CONTROL    = 8'h00; // interval_timer_control
    localparam logic [7:0]   OFS_STATUS     = 8'h04; // interval_timer_status
    localparam logic [7:0]   OFS_COUNTER    = 8'h08; // interval_counter
    localparam logic [7:0]   OFS_COMPARE    = 8'h0c; // interval_compare_value
    localparam logic [7:0]   OFS_MATCH_CNT  = 8'h10; // match_count_counter
    localparam logic [7:0]   OFS_MASTER_EN  = 8'h14; // master_enable_register

    // ========================================================================
    // field positions
    // ========================================================================
    localparam int           CTRL_IRQ_EN_BIT = 0;  // compare_irq_enable
    localparam int           CTRL_SEL_LSB    = 4;  // counter_clock_select lsb
    localparam int           CTRL_SEL_MSB    = 6;  // counter_clock_select msb
    localparam int           STAT_CMF_BIT    = 0;  // compare_match_flag
    localparam int           STAT_OVF1_BIT   = 1;  // interval_overflow_flag
    localparam int           STAT_OVF2_BIT   = 2;  // match_count_overflow_flag
    localparam int           MEN_ENABLE_BIT  = 0;  // master timer enable

    // ========================================================================
    // reset values
    // ========================================================================
    localparam logic [7:0]   CTRL_RESET      = 8'h00;
    localparam logic [7:0]   STAT_RESET      = 8'h00;
    localparam logic [15:0]  COUNTER_RESET   = 16'h0000;
    localparam logic [15:0]  COMPARE_RESET   = 16'hffff;
    localparam logic [31:0]  MATCH_CNT_RESET = 32'h0000_0000;
    localparam logic         MASTER_EN_RESET = 1'b0;

    // ========================================================================
    // clock-bus selection and byte-strobe patterns
    // ========================================================================
    localparam int           CLOCK_BUS_LINES = 6;    // lines 0..5
    localparam logic [3:0]   STRB_BYTE0      = 4'h1; // byte lane 0
    localparam logic [3:0]   STRB_WORD16     = 4'h3; // low 16-bit word
    localparam logic [3:0]   STRB_LONG       = 4'hf; // full longword

    // ========================================================================
    // carriers
    // ========================================================================
    typedef struct packed {
        logic [2:0] clk_sel;  // counter_clock_select
        logic       irq_en;   // compare_irq_enable
    } cit_ctrl_type;

    typedef struct packed {
        logic ovf2;  // match_count_overflow_flag
        logic ovf1;  // interval_overflow_flag
        logic cmf;   // compare_match_flag
    } cit_stat_type;

    typedef struct packed {
        logic                  sel;
        logic                  enable;
        logic                  write;
        logic [ADDR_WIDTH-1:0] addr;
        logic [31:0]           wdata;
        logic [3:0]            strb;
    } cit_apb_req_type;

endpackage

// ### rtl/cit_timer.sv
// cascaded interval timer with apb register slave
`timescale 1ns/1ps
// ============================================================================
// ============================================================================
module cit_timer
    import cit_pkg::*;
#(
    parameter int TICK_LINES = CLOCK_BUS_LINES  // clock-bus lines present
) (
    input  wire logic                   CORE_CLK_IN,     // peripheral clock
    input  wire logic                   NRST_IN,         // async reset, low
    input  wire logic                   STANDBY_IN,      // standby entry
    input  wire logic [TICK_LINES-1:0]  CLK_BUS_IN,      // tick enables
    input  wire logic                   PSEL_IN,         // apb select
    input  wire logic                   PENABLE_IN,      // apb access phase
    input  wire logic                   PWRITE_IN,       // apb direction
    input  wire logic [ADDR_WIDTH-1:0]  PADDR_IN,        // apb byte address
    input  wire logic [31:0]            PWDATA_IN,       // apb write data
    input  wire logic [3:0]             PSTRB_IN,        // apb byte strobes
    output logic                        PREADY_OUT,      // apb ready
    output logic [31:0]                 PRDATA_OUT,      // apb read data
    output logic                        PSLVERR_OUT,     // apb error
    output logic                        COMPARE_IRQ_OUT  // compare request
);

    // ========================================================================
    // elaboration check
    // ========================================================================
    // the 3-bit select field can address at most six legal lines
    // codes at or above the count never tick
    // so a short bus acts like a barred code
    if (TICK_LINES < 1 || TICK_LINES > CLOCK_BUS_LINES) begin : g_bad_lines
        $error("TICK_LINES must lie between 1 and 6");
    end

    // ========================================================================
    // helper functions
    // ========================================================================
    // true when strobes match the required access width exactly
    // scattered or partial strobes fail here
    function automatic logic width_ok(input logic [3:0] strb,
                                      input logic [3:0] need);
        width_ok = (strb == need);
    endfunction

    // byte or 16-bit word access, both reach lane 0
    // used by control, status and enable
    function automatic logic narrow_ok(input logic [3:0] strb);
        narrow_ok = width_ok(strb, STRB_BYTE0) || width_ok(strb, STRB_WORD16);
    endfunction

    // ========================================================================
    // state
    // ========================================================================
    // seen marks flags read back as one;
    // a zero write clears only those, so
    // a flag raised after the read holds
    cit_ctrl_type     ctrl;          // control register fields
    cit_stat_type     stat;          // sticky status flags
    cit_stat_type     seen;          // flags read back as one
    logic [15:0]      counter;       // interval_counter
    logic [15:0]      compare;       // interval_compare_value
    logic [31:0]      match_cnt;     // match_count_counter
    logic             master_en;     // master timer enable

    // next values
    cit_ctrl_type     next_ctrl;
    cit_stat_type     next_stat;
    cit_stat_type     next_seen;
    logic [15:0]      next_counter;
    logic [15:0]      next_compare;
    logic [31:0]      next_match_cnt;
    logic             next_master_en;
    logic             next_ready;
    logic [31:0]      next_rdata;
    logic             next_slverr;
    logic             next_irq;

    // ========================================================================
    // apb decode
    // ========================================================================
    // whole request kept as one bundle
    cit_apb_req_type  req;           // bundled request
    wire logic        setup_phase;   // first cycle of a transfer
    wire logic        access_done;   // access edge with ready high
    wire logic        wr_done;       // write takes effect now
    wire logic        hit_ctrl;
    wire logic        hit_stat;
    wire logic        hit_cnt;
    wire logic        hit_cmp;
    wire logic        hit_mcnt;
    wire logic        hit_men;
    wire logic        mapped;        // any register hit
    wire logic        wr_legal;      // write width accepted
    wire logic        wr_ctrl;
    wire logic        wr_stat;
    wire logic        wr_cnt;
    wire logic        wr_cmp;
    wire logic        wr_mcnt;
    wire logic        wr_men;

    assign req = '{sel: PSEL_IN, enable: PENABLE_IN, write: PWRITE_IN,
                   addr: PADDR_IN, wdata: PWDATA_IN, strb: PSTRB_IN};

    // data and error settle in setup and
    // are registered: never a wait state;
    // writes land on the access edge only
    assign setup_phase = req.sel && !req.enable;
    assign access_done = req.sel && req.enable && PREADY_OUT;
    assign hit_ctrl    = (req.addr == OFS_CONTROL);
    assign hit_stat    = (req.addr == OFS_STATUS);
    assign hit_cnt     = (req.addr == OFS_COUNTER);
    assign hit_cmp     = (req.addr == OFS_COMPARE);
    assign hit_mcnt    = (req.addr == OFS_MATCH_CNT);
    assign hit_men     = (req.addr == OFS_MASTER_EN);
    assign mapped      = hit_ctrl || hit_stat || hit_cnt || hit_cmp
                         || hit_mcnt || hit_men;

    // width policy per register
    assign wr_legal = ((hit_ctrl || hit_stat || hit_men)
                          && narrow_ok(req.strb))
                      || ((hit_cnt || hit_cmp)
                          && width_ok(req.strb, STRB_WORD16))
                      || (hit_mcnt && width_ok(req.strb, STRB_LONG));

    // a refused transfer touches nothing,
    // so the error gates every write
    assign wr_done = access_done && req.write && !PSLVERR_OUT;
    assign wr_ctrl = wr_done && hit_ctrl;
    assign wr_stat = wr_done && hit_stat;
    assign wr_cnt  = wr_done && hit_cnt;
    assign wr_cmp  = wr_done && hit_cmp;
    assign wr_mcnt = wr_done && hit_mcnt;
    assign wr_men  = wr_done && hit_men;

    // ========================================================================
    // counting datapath
    // ========================================================================
    wire logic        sel_legal;     // select code names a present line
    wire logic        tick;          // selected clock-bus line pulses
    wire logic        count_inc;     // interval counter steps now
    wire logic        match;         // counter equals compare
    wire logic        cnt_wrap;      // interval counter overflows
    wire logic        mcnt_wrap;     // match counter overflows
    wire logic [15:0] cnt_plus;
    wire logic [31:0] mcnt_plus;
    wire logic [15:0] cnt_auto;      // counter value without a write

    // bus lines are one-cycle enables;
    // a line tied high runs at the core
    // rate: clear and step share an edge
    // prohibited codes select nothing, so the counter idles
    assign sel_legal = (32'(ctrl.clk_sel) < TICK_LINES);
    assign tick      = sel_legal && CLK_BUS_IN[ctrl.clk_sel];
    assign count_inc = master_en && tick;
    // no compare activity while frozen
    // a frozen equal value matches on resume
    assign match     = master_en && (counter == compare);
    // compare zero matches right after a
    // clear: software's mistake, unguarded
    assign cnt_plus  = counter + 16'h0001;
    assign mcnt_plus = match_cnt + 32'h0000_0001;
    // wrap only from all ones, never from a zero write or start
    assign cnt_wrap  = count_inc && !match
                       && (counter == 16'hffff);
    assign mcnt_wrap = match && (match_cnt == 32'hffff_ffff);

    // match clears, or gives one when a tick coincides
    assign cnt_auto = match     ? (count_inc ? 16'h0001 : 16'h0000)
                    : count_inc ? cnt_plus
                    : counter;

    // ========================================================================
    // register next values
    // ========================================================================
    always_comb begin
        // defaults hold every register
        next_ctrl      = ctrl;
        next_stat      = stat;
        next_seen      = seen;
        next_compare   = compare;
        next_master_en = master_en;

        // control, reserved bits dropped
        if (wr_ctrl) begin
            next_ctrl.irq_en  = req.wdata[CTRL_IRQ_EN_BIT];
            next_ctrl.clk_sel = req.wdata[CTRL_SEL_MSB:CTRL_SEL_LSB];
        end
        if (wr_cmp) begin
            next_compare = req.wdata[15:0];  // zero is software's fault
        end
        if (wr_men) begin
            next_master_en = req.wdata[MEN_ENABLE_BIT];
        end

        // remember flags returned as one by a status read
        if (setup_phase && !req.write && hit_stat) begin
            next_seen = seen | stat;
        end

        // clear by zero after a read of one; ones are ignored
        if (wr_stat) begin
            if (!req.wdata[STAT_CMF_BIT] && seen.cmf) begin
                next_stat.cmf = 1'b0;
                next_seen.cmf = 1'b0;
            end
            if (!req.wdata[STAT_OVF1_BIT] && seen.ovf1) begin
                next_stat.ovf1 = 1'b0;
                next_seen.ovf1 = 1'b0;
            end
            if (!req.wdata[STAT_OVF2_BIT] && seen.ovf2) begin
                next_stat.ovf2 = 1'b0;
                next_seen.ovf2 = 1'b0;
            end
        end

        // hardware sets win over a same-cycle clear
        // so an event met by a clear is kept
        // and must be read and cleared again
        if (match) begin
            next_stat.cmf = 1'b1;
        end
        if (cnt_wrap) begin
            next_stat.ovf1 = 1'b1;
        end
        if (mcnt_wrap) begin
            next_stat.ovf2 = 1'b1;
        end

        // standby entry re-initialises like power-on reset
        // it outranks writes and events alike
        if (STANDBY_IN) begin
            next_ctrl      = cit_ctrl_type'(4'h0);
            next_stat      = cit_stat_type'(STAT_RESET[2:0]);
            next_seen      = cit_stat_type'(STAT_RESET[2:0]);
            next_compare   = COMPARE_RESET;
            next_master_en = MASTER_EN_RESET;
        end
    end

    // counters: a write beats the automatic value
    // wrap flags use the automatic path,
    // so a write meeting a wrap still flags
    always_comb begin
        next_counter   = wr_cnt  ? req.wdata[15:0] : cnt_auto;
        next_match_cnt = wr_mcnt ? req.wdata
                       : match   ? mcnt_plus
                       : match_cnt;
        if (STANDBY_IN) begin
            next_counter   = COUNTER_RESET;
            next_match_cnt = MATCH_CNT_RESET;
        end
    end

    // ========================================================================
    // apb answer and interrupt next values
    // ========================================================================
    always_comb begin
        // answer one cycle after setup, zero wait states
        next_ready  = setup_phase;
        next_slverr = setup_phase && (!mapped
                      || (req.write && !wr_legal));
        next_rdata  = 32'h0000_0000;
        if (setup_phase && !req.write) begin
            // reserved bits stay zero in every view
            unique case (1'b1)
                hit_ctrl: begin
                    next_rdata[CTRL_IRQ_EN_BIT]            = ctrl.irq_en;
                    next_rdata[CTRL_SEL_MSB:CTRL_SEL_LSB]  = ctrl.clk_sel;
                end
                hit_stat: begin
                    next_rdata[STAT_OVF2_BIT:STAT_CMF_BIT] = stat;
                end
                hit_cnt: begin
                    next_rdata[15:0] = counter;
                end
                hit_cmp: begin
                    next_rdata[15:0] = compare;
                end
                hit_mcnt: begin
                    next_rdata = match_cnt;
                end
                hit_men: begin
                    next_rdata[MEN_ENABLE_BIT] = master_en;
                end
                default: begin
                    next_rdata = 32'h0000_0000;  // unmapped reads zero
                end
            endcase
        end
        // level request from the registered flag and enable
        // next values keep the request in step
        // with the flag, with no extra lag
        next_irq = next_stat.cmf && next_ctrl.irq_en;
    end

    // ========================================================================
    // registers
    // ========================================================================
    // three groups share one reset, kept
    // apart only to keep processes short
    // software-visible state
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            ctrl      <= cit_ctrl_type'(4'h0);
            stat      <= cit_stat_type'(3'h0);
            seen      <= cit_stat_type'(3'h0);
            compare   <= COMPARE_RESET;
            master_en <= MASTER_EN_RESET;
        end else begin
            ctrl      <= next_ctrl;
            stat      <= next_stat;
            seen      <= next_seen;
            compare   <= next_compare;
            master_en <= next_master_en;
        end
    end

    // the two cascaded counters
    // both hold while the enable is clear
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            counter   <= COUNTER_RESET;
            match_cnt <= MATCH_CNT_RESET;
        end else begin
            counter   <= next_counter;
            match_cnt <= next_match_cnt;
        end
    end

    // bus answer and interrupt outputs, all from flip-flops
    // bus answer low outside the access cycle, so a
    // late sampler sees zeros, not stale data
    always_ff @(posedge CORE_CLK_IN or negedge NRST_IN) begin
        if (!NRST_IN) begin
            PREADY_OUT      <= 1'b0;
            PRDATA_OUT      <= 32'h0000_0000;
            PSLVERR_OUT     <= 1'b0;
            COMPARE_IRQ_OUT <= 1'b0;
        end else begin
            PREADY_OUT      <= next_ready;
            PRDATA_OUT      <= next_rdata;
            PSLVERR_OUT     <= next_slverr;
            COMPARE_IRQ_OUT <= next_irq;
        end
    end

endmodule // cit_timer

// ### dv/cit_timer_asserts.sv
// checker: bus timing and status properties of the interval timer
`timescale 1ns/1ps
module cit_timer_asserts
    import cit_pkg::*;
#(
    parameter int TICK_LINES = CLOCK_BUS_LINES  // clock-bus lines present
) (
    input  wire logic                  CORE_CLK_IN,
    input  wire logic                  NRST_IN,
    input  wire logic                  STANDBY_IN,
    input  wire logic [TICK_LINES-1:0] CLK_BUS_IN,
    input  wire logic                  PSEL_IN,
    input  wire logic                  PENABLE_IN,
    input  wire logic                  PWRITE_IN,
    input  wire logic [ADDR_WIDTH-1:0] PADDR_IN,
    input  wire logic [31:0]           PWDATA_IN,
    input  wire logic [3:0]            PSTRB_IN,
    input  wire logic                  PREADY_OUT,
    input  wire logic [31:0]           PRDATA_OUT,
    input  wire logic                  PSLVERR_OUT,
    input  wire logic                  COMPARE_IRQ_OUT
);
    // ========================================================================
    // helpers
    // ========================================================================
    wire logic setup    = PSEL_IN && !PENABLE_IN;  // apb setup cycle
    wire logic rd_setup = setup && !PWRITE_IN;     // read setup cycle
    wire logic ctrl_wr  = PSEL_IN && PENABLE_IN && PREADY_OUT && PWRITE_IN
                          && PADDR_IN == OFS_CONTROL && !PSLVERR_OUT;

    default clocking cb @(posedge CORE_CLK_IN); endclocking
    default disable iff (!NRST_IN);

    // ========================================================================
    // properties
    // ========================================================================
    property p_ready_after_setup; setup |=> PREADY_OUT; endproperty
    a_ready_after_setup: assert property (p_ready_after_setup)
        else $error("no ready after setup");
    property p_ready_single; PREADY_OUT |=> !PREADY_OUT; endproperty
    a_ready_single: assert property (p_ready_single)
        else $error("ready longer than one cycle");
    property p_rdata_idle; !PREADY_OUT |-> PRDATA_OUT == 32'h0; endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data outside access");
    property p_status_reserved;
        rd_setup && PADDR_IN == OFS_STATUS |=> PRDATA_OUT[31:3] == '0;
    endproperty
    a_status_reserved: assert property (p_status_reserved)
        else $error("status reserved bits set");
    property p_ctrl_reserved;
        rd_setup && PADDR_IN == OFS_CONTROL
            |=> PRDATA_OUT[31:7] == '0 && PRDATA_OUT[3:1] == '0;
    endproperty
    a_ctrl_reserved: assert property (p_ctrl_reserved)
        else $error("control reserved bits set");
    property p_unmapped;
        setup && PADDR_IN > OFS_MASTER_EN |=> PSLVERR_OUT && PRDATA_OUT == 0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not refused");
    property p_width_refused;
        setup && PWRITE_IN && PADDR_IN == OFS_COUNTER
            && PSTRB_IN != STRB_WORD16 |=> PSLVERR_OUT;
    endproperty
    a_width_refused: assert property (p_width_refused)
        else $error("narrow counter write not refused");
    property p_irq_disable; ctrl_wr && !PWDATA_IN[0] |=> !COMPARE_IRQ_OUT;
    endproperty
    a_irq_disable: assert property (p_irq_disable)
        else $error("request while enable cleared");
    property p_standby; STANDBY_IN [*2] |=> !COMPARE_IRQ_OUT; endproperty
    a_standby: assert property (p_standby)
        else $error("request during standby");
endmodule // cit_timer_asserts

bind cit_timer cit_timer_asserts #(.TICK_LINES(TICK_LINES)) u_chk (
    .CORE_CLK_IN(CORE_CLK_IN), .NRST_IN(NRST_IN), .STANDBY_IN(STANDBY_IN),
    .CLK_BUS_IN(CLK_BUS_IN), .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN),
    .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN), .PWDATA_IN(PWDATA_IN),
    .PSTRB_IN(PSTRB_IN), .PREADY_OUT(PREADY_OUT), .PRDATA_OUT(PRDATA_OUT),
    .PSLVERR_OUT(PSLVERR_OUT), .COMPARE_IRQ_OUT(COMPARE_IRQ_OUT));

// ### dv/cit_timer_tb.sv
// self-checking bench for the cascaded interval timer
`timescale 1ns/1ps
module cit_timer_tb import cit_pkg::*;;
    // ========================================================================
    // stimulus and observation
    // ========================================================================
    logic            clk    = 1'b0;  // peripheral clock
    logic            nrst   = 1'b0;  // reset, active low
    logic            stby   = 1'b0;  // standby entry
    logic [5:0]      tick   = 6'h00; // clock-bus lines
    cit_apb_req_type req    = '0;    // apb request bundle
    logic [31:0]     rdata;          // read data
    logic            pready;         // ready
    logic            perr;           // slave error
    logic            irq;            // compare request
    logic [31:0]     got;            // last read data
    logic            err;            // last error flag
    int              n_fail = 0;     // mismatches
    int              total_checks = 0; // comparisons

    always #50 clk = ~clk;  // 10 MHz

    cit_timer uut (.CORE_CLK_IN(clk), .NRST_IN(nrst), .STANDBY_IN(stby),
        .CLK_BUS_IN(tick), .PSEL_IN(req.sel), .PENABLE_IN(req.enable),
        .PWRITE_IN(req.write), .PADDR_IN(req.addr), .PWDATA_IN(req.wdata),
        .PSTRB_IN(req.strb), .PREADY_OUT(pready), .PRDATA_OUT(rdata),
        .PSLVERR_OUT(perr), .COMPARE_IRQ_OUT(irq));

    // ========================================================================
    // tasks
    // ========================================================================
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        total_checks++;
        if (g !== e) begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // one apb transfer, held until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int k = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, w, a, d, s};
        @(posedge clk);
        req.enable <= 1'b1;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (k >= 20) n_fail++;
        got = rdata;
        err = perr;
        req <= '0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0, 4'h0);
        chk(got, e);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        apb(1'b1, a, d, s);
    endtask
    // one-cycle pulses on a clock-bus line, with gaps
    task automatic pulse(input int line, input int n);
        repeat (n) begin
            @(posedge clk);
            tick <= 6'h01 << line;
            @(posedge clk);
            tick <= 6'h00;
        end
    endtask
    task automatic chk_irq(input logic e);
        #1;
        chk({31'h0, irq}, {31'h0, e});
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask

    // ========================================================================
    // watchdog and test sequence
    // ========================================================================
    initial begin
        #1ms;
        n_fail++;
        wrap_up;
    end

    initial begin
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        rd(OFS_CONTROL, 32'h0);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_COUNTER, 32'h0);
        rd(OFS_COMPARE, 32'h0000ffff);
        rd(OFS_MATCH_CNT, 32'h0);
        $display("test reset done");
        wr(OFS_CONTROL, 32'hffffffff, STRB_BYTE0);
        rd(OFS_CONTROL, 32'h00000071);
        wr(OFS_COUNTER, 32'h00001234, STRB_LONG);
        chk({31'h0, err}, 32'h1);
        rd(OFS_COUNTER, 32'h0);
        rd(8'h18, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("test access done");
        wr(OFS_CONTROL, 32'h21, STRB_BYTE0);  // line 2, request on
        wr(OFS_COMPARE, 32'h3, STRB_WORD16);
        wr(OFS_MASTER_EN, 32'h1, STRB_BYTE0);
        pulse(1, 3);
        rd(OFS_COUNTER, 32'h0);
        pulse(2, 2);
        rd(OFS_COUNTER, 32'h2);
        pulse(2, 1);
        rd(OFS_COUNTER, 32'h0);
        rd(OFS_MATCH_CNT, 32'h1);
        rd(OFS_STATUS, 32'h1);
        chk_irq(1'b1);
        $display("test match done");
        wr(OFS_STATUS, 32'h1, STRB_BYTE0);
        rd(OFS_STATUS, 32'h1);
        wr(OFS_STATUS, 32'h0, STRB_BYTE0);
        rd(OFS_STATUS, 32'h0);
        chk_irq(1'b0);
        pulse(2, 3);
        wr(OFS_STATUS, 32'h0, STRB_BYTE0);  // no read before clear
        rd(OFS_STATUS, 32'h1);
        pulse(2, 3);
        rd(OFS_MATCH_CNT, 32'h3);
        wr(OFS_CONTROL, 32'h20, STRB_BYTE0);
        chk_irq(1'b0);
        $display("test flags done");
        wr(OFS_STATUS, 32'h0, STRB_BYTE0);
        wr(OFS_COUNTER, 32'h0, STRB_WORD16);
        rd(OFS_STATUS, 32'h0);
        wr(OFS_COUNTER, 32'hffff, STRB_WORD16);
        pulse(2, 1);
        rd(OFS_COUNTER, 32'h0);
        rd(OFS_STATUS, 32'h2);
        wr(OFS_MATCH_CNT, 32'hffffffff, STRB_LONG);
        pulse(2, 3);
        rd(OFS_MATCH_CNT, 32'h0);
        rd(OFS_STATUS, 32'h7);
        $display("test overflow done");
        pulse(2, 1);
        wr(OFS_MASTER_EN, 32'h0, STRB_BYTE0);
        pulse(2, 2);
        rd(OFS_COUNTER, 32'h1);
        wr(OFS_MASTER_EN, 32'h1, STRB_BYTE0);
        pulse(2, 1);
        rd(OFS_COUNTER, 32'h2);
        wr(OFS_STATUS, 32'h0, STRB_BYTE0);
        wr(OFS_COUNTER, 32'hffff, STRB_WORD16);
        fork
            wr(OFS_COUNTER, 32'h5, STRB_WORD16);
            begin
                repeat (2) @(posedge clk);
                tick <= 6'h04;
                @(posedge clk);
                tick <= 6'h00;
            end
        join
        rd(OFS_COUNTER, 32'h5);
        rd(OFS_STATUS, 32'h2);
        wr(OFS_COUNTER, 32'h0, STRB_WORD16);
        wr(OFS_COMPARE, 32'h1, STRB_WORD16);
        tick <= 6'h04;
        rd(OFS_COUNTER, 32'h1);
        rd(OFS_COUNTER, 32'h1);
        $display("test coincide done");
        @(posedge clk);
        stby <= 1'b1;
        tick <= 6'h00;
        repeat (2) @(posedge clk);
        stby <= 1'b0;
        rd(OFS_COMPARE, 32'h0000ffff);
        rd(OFS_STATUS, 32'h0);
        rd(OFS_CONTROL, 32'h0);
        rd(OFS_COUNTER, 32'h0);
        rd(OFS_MATCH_CNT, 32'h0);
        $display("test standby done");
        wrap_up;
    end
endmodule // cit_timer_tb
